// File: design/rid_pkg.sv
// Function
// - Accept each instruction as one 14-bit word
// - Sort every word into exactly one group
// - Byte operations carry register and destination operands
// - Destination zero writes result to working register
// - Destination one writes result to file register
// - Bit operations carry bit select and register
// - Literal operations carry eight or eleven bits
// - Four oscillator periods make one instruction cycle
// - Instructions normally finish in one cycle
// - Skip or jump adds a padding no-operation cycle
// - Register instructions read before they write back
// - Register operand spans addresses 0x00 to 0x7F
`default_nettype none
package rid_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Word layout.
	localparam int WORD_W  = 14;
	localparam int OP_W    = 4;
	localparam int FILE_W  = 7;
	localparam int BSEL_W  = 3;
	localparam int LIT8_W  = 8;
	localparam int LIT11_W = 11;
	localparam int PH_W    = 2;

	localparam int GRP_HI     = 13;
	localparam int GRP_LO     = 12;
	localparam int BOP_HI     = 11;
	localparam int BOP_LO     = 8;
	localparam int DEST_POS   = 7;
	localparam int FILE_HI    = 6;
	localparam int FILE_LO    = 0;
	localparam int BITOP_HI   = 11;
	localparam int BITOP_LO   = 10;
	localparam int BSEL_HI    = 9;
	localparam int BSEL_LO    = 7;
	localparam int LOP_HI     = 11;
	localparam int LOP_LO     = 10;

	// Group codes in the top two bits.
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT  = 2'h1;
	localparam logic [1:0] GRP_JUMP = 2'h2;
	localparam logic [1:0] GRP_LIT  = 2'h3;

	// Selected operation codes.
	localparam logic [3:0] BOP_CTRL     = 4'h0;
	localparam logic [3:0] BOP_CLR      = 4'h1;
	localparam logic [3:0] BOP_DEC_SKIP = 4'hb;
	localparam logic [3:0] BOP_INC_SKIP = 4'hf;
	localparam logic [1:0] BITOP_TSTC   = 2'h2;
	localparam logic [1:0] LOP_RETLIT   = 2'h1;
	localparam logic [6:0] CTRL_RET     = 7'h08;
	localparam logic [6:0] CTRL_RETI    = 7'h09;

	// Register operand range.
	localparam logic [6:0] FILE_MIN = 7'h00;
	localparam logic [6:0] FILE_MAX = 7'h7f;

	// Reset and padding word is the padding no-operation.
	localparam logic [13:0] PAD_WORD = 14'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int OSC_PER_CYCLE  = 4;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int INSTR_CYCLE_NS = OSC_PER_CYCLE * CLK_PERIOD_NS;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q4 = 2'h3;

	typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LITCTRL} rid_class_t;
	typedef enum logic {ST_EXEC, ST_PAD} rid_state_t;

endpackage : rid_pkg
`default_nettype wire

// File: design/rid_phase_gen.sv
`default_nettype none
module rid_phase_gen #(
	parameter int PHASES = rid_pkg::OSC_PER_CYCLE
) (
	// Clock and reset.
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Phase outputs.
	output logic      [rid_pkg::PH_W-1:0] phase_o,
	output logic                          first_o,
	output logic                          last_o
);
	import rid_pkg::*;

	logic [PH_W-1:0] phase_r;
	logic [PH_W-1:0] phase_nxt;

	always_comb begin
		if (phase_r == PH_W'(PHASES - 1)) begin
			phase_nxt = '0;
		end else begin
			phase_nxt = phase_r + PH_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r <= '0;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign phase_o = phase_r;
	assign first_o = (phase_r == '0);
	assign last_o  = (phase_r == PH_W'(PHASES - 1));

endmodule : rid_phase_gen
`default_nettype wire

// File: design/rid_decoder.sv
`default_nettype none
module rid_decoder (
	// Clock and reset.
	input  wire logic                          CLK_I,
	input  wire logic                          RST_I,
	// Program memory side.
	input  wire logic [rid_pkg::WORD_W-1:0]    INSTR_I,
	output logic                               FETCH_O,
	// Datapath test result, valid in the fourth phase.
	input  wire logic                          SKIP_TRUE_I,
	// Cycle timing.
	output logic      [rid_pkg::PH_W-1:0]      PHASE_O,
	output logic                               CYCLE_START_O,
	output logic                               PAD_O,
	// Decoded operands.
	output rid_pkg::rid_class_t                CLASS_O,
	output logic      [rid_pkg::OP_W-1:0]      ALU_OP_O,
	output logic      [rid_pkg::FILE_W-1:0]    FILE_ADDR_O,
	output logic                               DEST_F_O,
	output logic      [rid_pkg::BSEL_W-1:0]    BIT_SEL_O,
	output logic      [rid_pkg::LIT8_W-1:0]    LIT8_O,
	output logic      [rid_pkg::LIT11_W-1:0]   LIT11_O,
	output logic                               LIT_WIDE_O,
	// Strobes to register file and program counter.
	output logic                               FILE_RD_O,
	output logic                               WR_W_O,
	output logic                               WR_F_O,
	output logic                               SKIP_TEST_O,
	output logic                               FLOW_CHANGE_O,
	output logic                               FLOW_LOAD_O,
	output logic                               FLOW_POP_O
);
	import rid_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers for decode; f_group is also shared with the checks.
	function automatic logic [1:0] f_group(input logic [WORD_W-1:0] w);
		f_group = w[GRP_HI:GRP_LO];
	endfunction : f_group

	function automatic logic f_is_ctrl(input logic [WORD_W-1:0] w);
		f_is_ctrl = (w[GRP_HI:GRP_LO] == GRP_BYTE) && (w[BOP_HI:BOP_LO] == BOP_CTRL)
			&& !w[DEST_POS];
	endfunction : f_is_ctrl

	////////////////////////////////////////////////////////////////////////////
	// Phase divider.
	logic [PH_W-1:0] phase;
	logic            ph_first;
	logic            ph_last;

	rid_phase_gen #(
		.PHASES (OSC_PER_CYCLE)
	) u_phase (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.phase_o (phase),
		.first_o (ph_first),
		.last_o  (ph_last)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decoded instruction state.
	rid_state_t         state_r,  state_nxt;
	rid_class_t         cls_r,    cls_nxt;
	logic [OP_W-1:0]    op_r,     op_nxt;
	logic [FILE_W-1:0]  file_r,   file_nxt;
	logic               dest_r,   dest_nxt;
	logic [BSEL_W-1:0]  bsel_r,   bsel_nxt;
	logic [LIT8_W-1:0]  lit8_r,   lit8_nxt;
	logic [LIT11_W-1:0] lit11_r,  lit11_nxt;
	logic               wide_r,   wide_nxt;
	logic               rmw_r,    rmw_nxt;
	logic               wrw_r,    wrw_nxt;
	logic               wrf_r,    wrf_nxt;
	logic               skipi_r,  skipi_nxt;
	logic               jmp_r,    jmp_nxt;
	logic               load_r,   load_nxt;
	logic               pop_r,    pop_nxt;
	logic               pad_go;
	logic [WORD_W-1:0]  src;

	assign pad_go = (state_r == ST_EXEC) && (jmp_r || (skipi_r && SKIP_TRUE_I));

	always_comb begin
		src       = pad_go ? PAD_WORD : INSTR_I;
		state_nxt = state_r;
		cls_nxt   = cls_r;
		op_nxt    = op_r;
		file_nxt  = file_r;
		dest_nxt  = dest_r;
		bsel_nxt  = bsel_r;
		lit8_nxt  = lit8_r;
		lit11_nxt = lit11_r;
		wide_nxt  = wide_r;
		rmw_nxt   = rmw_r;
		wrw_nxt   = wrw_r;
		wrf_nxt   = wrf_r;
		skipi_nxt = skipi_r;
		jmp_nxt   = jmp_r;
		load_nxt  = load_r;
		pop_nxt   = pop_r;
		if (ph_last) begin
			state_nxt = pad_go ? ST_PAD : ST_EXEC;
			op_nxt    = src[BOP_HI:BOP_LO];
			file_nxt  = src[FILE_HI:FILE_LO];
			dest_nxt  = src[DEST_POS];
			bsel_nxt  = src[BSEL_HI:BSEL_LO];
			lit8_nxt  = src[LIT8_W-1:0];
			lit11_nxt = src[LIT11_W-1:0];
			wide_nxt  = 1'b0;
			rmw_nxt   = 1'b0;
			wrw_nxt   = 1'b0;
			wrf_nxt   = 1'b0;
			skipi_nxt = 1'b0;
			jmp_nxt   = 1'b0;
			load_nxt  = 1'b0;
			pop_nxt   = 1'b0;
			case (f_group(src))
				GRP_BYTE: begin
					if (f_is_ctrl(src)) begin
						cls_nxt = CLS_LITCTRL;
						jmp_nxt = (src[FILE_HI:FILE_LO] == CTRL_RET)
							|| (src[FILE_HI:FILE_LO] == CTRL_RETI);
						pop_nxt = jmp_nxt;
					end else begin
						cls_nxt   = CLS_BYTE;
						// clear of W names no register
						rmw_nxt   = !((src[BOP_HI:BOP_LO] == BOP_CLR) && !src[DEST_POS]);
						wrw_nxt   = !src[DEST_POS];
						wrf_nxt   = src[DEST_POS];
						skipi_nxt = (src[BOP_HI:BOP_LO] == BOP_DEC_SKIP)
							|| (src[BOP_HI:BOP_LO] == BOP_INC_SKIP);
					end
				end
				GRP_BIT: begin
					cls_nxt   = CLS_BIT;
					rmw_nxt   = 1'b1;
					wrf_nxt   = src[BITOP_HI:BITOP_LO] < BITOP_TSTC;
					skipi_nxt = src[BITOP_HI:BITOP_LO] >= BITOP_TSTC;
				end
				GRP_JUMP: begin
					cls_nxt  = CLS_LITCTRL;
					wide_nxt = 1'b1;
					jmp_nxt  = 1'b1;
					load_nxt = 1'b1;
				end
				GRP_LIT: begin
					cls_nxt = CLS_LITCTRL;
					wrw_nxt = 1'b1;
					jmp_nxt = (src[LOP_HI:LOP_LO] == LOP_RETLIT);
					pop_nxt = jmp_nxt;
				end
				default: begin
					cls_nxt = CLS_LITCTRL;
				end
			endcase
		end
	end

	// Reset starts in a padding cycle so the first word is fetched cleanly.
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_r <= ST_PAD;
			cls_r   <= CLS_LITCTRL;
			op_r    <= '0;
			file_r  <= '0;
			dest_r  <= 1'b0;
			bsel_r  <= '0;
			lit8_r  <= '0;
			lit11_r <= '0;
			wide_r  <= 1'b0;
			rmw_r   <= 1'b0;
			wrw_r   <= 1'b0;
			wrf_r   <= 1'b0;
			skipi_r <= 1'b0;
			jmp_r   <= 1'b0;
			load_r  <= 1'b0;
			pop_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cls_r   <= cls_nxt;
			op_r    <= op_nxt;
			file_r  <= file_nxt;
			dest_r  <= dest_nxt;
			bsel_r  <= bsel_nxt;
			lit8_r  <= lit8_nxt;
			lit11_r <= lit11_nxt;
			wide_r  <= wide_nxt;
			rmw_r   <= rmw_nxt;
			wrw_r   <= wrw_nxt;
			wrf_r   <= wrf_nxt;
			skipi_r <= skipi_nxt;
			jmp_r   <= jmp_nxt;
			load_r  <= load_nxt;
			pop_r   <= pop_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign FETCH_O       = ph_last && !pad_go;
	assign PHASE_O       = phase;
	assign CYCLE_START_O = ph_first;
	assign PAD_O         = (state_r == ST_PAD);
	assign CLASS_O       = cls_r;
	assign ALU_OP_O      = op_r;
	assign FILE_ADDR_O   = file_r;
	assign DEST_F_O      = dest_r;
	assign BIT_SEL_O     = bsel_r;
	assign LIT8_O        = lit8_r;
	assign LIT11_O       = lit11_r;
	assign LIT_WIDE_O    = wide_r;
	// read in Q2, write in Q4
	assign FILE_RD_O     = rmw_r && (phase == PH_Q2);
	assign WR_W_O        = wrw_r && ph_last;
	assign WR_F_O        = wrf_r && ph_last;
	assign SKIP_TEST_O   = skipi_r && ph_last;
	assign FLOW_CHANGE_O = jmp_r && ph_last;
	assign FLOW_LOAD_O   = load_r && ph_last;
	assign FLOW_POP_O    = pop_r && ph_last;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	cycle_length_a: assert property (
		CYCLE_START_O |=> !CYCLE_START_O [*3] ##1 CYCLE_START_O)
		else $error("instruction cycle is not four clocks");

	word_taken_a: assert property (
		FETCH_O |=> CYCLE_START_O && !PAD_O)
		else $error("fetched word did not start a cycle");

	group_bit_a: assert property (
		FETCH_O ##1 (f_group($past(INSTR_I)) == GRP_BIT) |-> CLASS_O == CLS_BIT)
		else $error("bit group word not classed as bit operation");

	dest_taken_a: assert property (
		FETCH_O |=> DEST_F_O == $past(INSTR_I[DEST_POS]))
		else $error("destination select not taken from word");

	dest_w_a: assert property (
		(WR_W_O && CLASS_O == CLS_BYTE) |-> !DEST_F_O && !WR_F_O)
		else $error("working register written with destination one");

	dest_f_a: assert property (
		(WR_F_O && CLASS_O == CLS_BYTE) |-> DEST_F_O && !WR_W_O)
		else $error("file register written with destination zero");

	bit_fields_a: assert property (
		FETCH_O |=> BIT_SEL_O == $past(INSTR_I[BSEL_HI:BSEL_LO])
			&& FILE_ADDR_O == $past(INSTR_I[FILE_HI:FILE_LO]))
		else $error("bit select or register operand mismatch");

	lit_wide_a: assert property (
		FETCH_O ##1 (f_group($past(INSTR_I)) == GRP_JUMP)
			|-> LIT_WIDE_O && LIT11_O == $past(INSTR_I[LIT11_W-1:0]))
		else $error("eleven-bit literal not taken");

	single_cycle_a: assert property (
		(ph_last && !PAD_O && !jmp_r && !(skipi_r && SKIP_TRUE_I)) |=> !PAD_O)
		else $error("padding cycle without skip or jump");

	pad_after_a: assert property (
		FLOW_CHANGE_O |=> PAD_O [*4] ##1 !PAD_O)
		else $error("jump not followed by one padding cycle");

	pad_quiet_a: assert property (
		PAD_O |-> !FILE_RD_O && !WR_W_O && !WR_F_O && !FLOW_CHANGE_O)
		else $error("padding cycle performed work");

	read_first_a: assert property (
		(WR_F_O && CLASS_O != CLS_LITCTRL) |-> $past(FILE_RD_O, 2))
		else $error("file register written without prior read");

endmodule : rid_decoder
`default_nettype wire

// File: test/rid_pmem_model.sv
`default_nettype none
module rid_pmem_model (
	// Clock.
	input  wire logic        clk_i,
	// Fetch handshake.
	input  wire logic        fetch_i,
	output logic      [13:0] instr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] words_q[$];

	task automatic push(input logic [13:0] w);
		words_q.push_back(w);
		if (words_q.size() == 1) instr_o = w;
	endtask : push

	always @(posedge clk_i) begin
		if (fetch_i && words_q.size() > 0) begin
			void'(words_q.pop_front());
			// An empty store no longer holds the old word, so its inverse is shown.
			instr_o <= (words_q.size() > 0) ? words_q[0] : ~instr_o;
		end
	end
endmodule : rid_pmem_model
`default_nettype wire

// File: test/rid_decoder_test.sv
`default_nettype none
module rid_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	import rid_pkg::*;
	logic        CLK_I;
	logic        RST_I;
	logic        SKIP_TRUE_I;
	logic [13:0] instr;
	logic        fetch;
	logic [1:0]  phase;
	logic        start;
	logic        pad;
	rid_class_t  cls;
	logic [3:0]  alu_op;
	logic [6:0]  faddr;
	logic        dest_f;
	logic [2:0]  bsel;
	logic [7:0]  lit8;
	logic [10:0] lit11;
	logic        lwide;
	logic [6:0]  strb;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          gap;
	integer      seed = 32'h261323df;
	logic [13:0] exp_q[$];
	logic [13:0] w;
	logic [6:0]  v;
	logic        live;
	logic        exp_pad;
	logic        f;

	rid_decoder u_dut (.CLK_I(CLK_I), .RST_I(RST_I), .INSTR_I(instr), .FETCH_O(fetch),
		.SKIP_TRUE_I(SKIP_TRUE_I), .PHASE_O(phase), .CYCLE_START_O(start), .PAD_O(pad),
		.CLASS_O(cls), .ALU_OP_O(alu_op), .FILE_ADDR_O(faddr), .DEST_F_O(dest_f),
		.BIT_SEL_O(bsel), .LIT8_O(lit8), .LIT11_O(lit11), .LIT_WIDE_O(lwide),
		.FILE_RD_O(strb[6]), .WR_W_O(strb[5]), .WR_F_O(strb[4]), .SKIP_TEST_O(strb[3]),
		.FLOW_CHANGE_O(strb[2]), .FLOW_LOAD_O(strb[1]), .FLOW_POP_O(strb[0]));
	rid_pmem_model u_pm (.clk_i(CLK_I), .fetch_i(fetch), .instr_o(instr));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// Strobes {read, write W, write f, skip test, jump, load, pop} a word should raise.
	function automatic logic [6:0] exp_strb(input logic [13:0] x);
		logic ctl;
		logic [6:0] r;
		ctl = x[13:12] == 2'h0 && x[11:8] == 4'h0 && !x[7];
		r = 7'h00;
		case (x[13:12])
			2'h0: begin
				r[6] = !(ctl || (x[11:8] == 4'h1 && !x[7]));
				r[5] = !x[7] && !ctl;
				r[4] = x[7];
				r[3] = x[11:8] == 4'hb || x[11:8] == 4'hf;
				r[2] = ctl && (x[6:0] == 7'h08 || x[6:0] == 7'h09);
				r[0] = r[2];
			end
			2'h1: begin
				r[6] = 1'b1;
				r[4] = !x[11];
				r[3] = x[11];
			end
			2'h2: r[2:1] = 2'h3;
			default: begin
				r[5] = 1'b1;
				r[2] = x[11:10] == 2'h1;
				r[0] = r[2];
			end
		endcase
		return r;
	endfunction : exp_strb

	////////////////////////////////////////////////////////////////////////////
	initial begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end

	always @(posedge CLK_I) begin
		#1 SKIP_TRUE_I = $random(seed) & 1;
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic send(input logic [13:0] x);
		u_pm.push(x);
		exp_q.push_back(x);
	endtask : send

	initial begin
		RST_I = 1'b1;
		SKIP_TRUE_I = 1'b0;
		// Boundary register addresses alternate between the lowest and highest.
		for (int i = 0; i < 32; i++) send({2'h0, 4'(i >> 1), 1'(i), (i % 4 < 2) ? 7'h00 : 7'h7f});
		for (int i = 0; i < 32; i++) send({2'h1, 2'(i >> 3), 3'(i), (i % 2) ? 7'h7f : 7'h00});
		for (int i = 0; i < 16; i++) send({2'h3, 4'(i), 8'($random(seed))});
		send({7'h00, CTRL_RET});
		send({7'h00, CTRL_RETI});
		for (int i = 0; i < 150; i++) send(14'($random(seed)));
		// A closing padding word leaves the drained store on an all-ones word that never jumps.
		send(PAD_WORD);
		repeat (16) @(posedge CLK_I);
		#1 RST_I = 1'b0;
		while (exp_q.size() != 0) @(posedge CLK_I);
		repeat (8) @(posedge CLK_I);
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////
	always @(negedge CLK_I) begin
		if (RST_I) begin
			gap = 3;
			exp_pad = 1'b1;
			live = 1'b0;
		end else begin
			gap++;
			if (start) begin
				chk(16'(gap), 16'h4);
				gap = 0;
				chk(16'(pad), 16'(exp_pad));
				live = !pad && exp_q.size() > 0;
				exp_pad = 1'b0;
				if (live) begin
					w = exp_q.pop_front();
					v = exp_strb(w);
					// Control words live in the byte space but belong to the control group.
					chk(16'(cls), (w[13:12] == 2'h1) ? 16'(CLS_BIT) :
						(w[13:12] == 2'h0 && (w[11:8] != 4'h0 || w[7])) ? 16'(CLS_BYTE) :
						16'(CLS_LITCTRL));
					case (w[13:12])
						2'h0: chk({4'h0, alu_op, dest_f, faddr}, {4'h0, w[11:0]});
						2'h1: chk({6'h0, bsel, faddr}, {6'h0, w[9:0]});
						2'h2: chk({4'h1, lwide, lit11}, {4'h1, 1'b1, w[10:0]});
						default: chk({7'h0, lwide, lit8}, {7'h0, 1'b0, w[7:0]});
					endcase
				end
			end
			chk(16'(phase), 16'(gap));
			if (pad) begin
				chk(16'(strb), 16'h0);
			end else if (live) begin
				chk(16'(strb), (phase == PH_Q2) ? 16'(v & 7'h40) :
					(phase == PH_Q4) ? 16'(v & 7'h3f) : 16'h0);
			end
			if (pad || live) begin
				// A taken skip or a jump forbids the fetch and pads the next cycle.
				f = pad || !(v[2] || (v[3] && SKIP_TRUE_I));
				chk(16'(fetch), (phase == PH_Q4) ? 16'(f) : 16'h0);
				if (phase == PH_Q4) exp_pad = !f;
			end
		end
	end
endmodule : rid_decoder_test
`default_nettype wire
